// ==== src/msk_pkg.sv ====
// Shared constants and types of the in-band MSK modem register block.
package msk_pkg;
   localparam logic [7:0] MSK_ADDR_CTRL = 8'hc8;
   localparam logic [7:0] MSK_ADDR_BUF = 8'hc9;
   localparam logic [7:0] MSK_ADDR_STAT = 8'hca;
   localparam logic [7:0] MSK_CTRL_RESET = 8'h00;
   localparam logic [7:0] MSK_STAT_RESET = 8'h00;
   localparam logic [7:0] MSK_READ_ZERO = 8'h00;
   // Control register fields.
   localparam int MSK_CTRL_RX_EN = 0;
   localparam int MSK_CTRL_TX_EN = 1;
   localparam int MSK_CTRL_BAUD_LO = 2;
   localparam int MSK_CTRL_BAUD_HI = 3;
   localparam int MSK_CTRL_PRE_LO = 4;
   localparam int MSK_CTRL_PRE_HI = 7;
   // Status register fields; bit 6 is unused and reads zero.
   localparam int MSK_ST_RX_IRQ = 0;
   localparam int MSK_ST_TX_IRQ = 1;
   localparam int MSK_ST_LOCK = 2;
   localparam int MSK_ST_PRE = 3;
   localparam int MSK_ST_ERR = 4;
   localparam int MSK_ST_FULL = 5;
   localparam int MSK_ST_POL = 7;
   // Codes for the external resistive DAC.
   localparam logic [2:0] MSK_DAC_OFF = 3'h7;
   localparam logic [2:0] MSK_DAC_IDLE = 3'h4;
   localparam logic [2:0] MSK_DAC_HIGH = 3'h6;
   localparam logic [2:0] MSK_DAC_LOW = 3'h2;
   // Line timing and framing.
   localparam int MSK_CLK_HZ = 40_000_000;
   localparam int MSK_BASE_BAUD = 1200;
   localparam int MSK_SAMPLES_PER_BIT = 8;
   localparam int MSK_SAMPLE_DIV_BASE = MSK_CLK_HZ / (MSK_SAMPLES_PER_BIT * MSK_BASE_BAUD);
   localparam int MSK_LOCK_BITS = 3;
   localparam int MSK_BYTE_BITS = 8;
   localparam logic [11:0] MSK_PREAMBLE_FIXED = 12'haaa;
   localparam logic [1:0] MSK_BAUD_1200 = 2'h0;
   localparam logic [1:0] MSK_BAUD_2400 = 2'h1;
   localparam logic [1:0] MSK_BAUD_3600 = 2'h2;
   localparam logic [1:0] MSK_BAUD_4800 = 2'h3;
   typedef enum logic [1:0] {
      MSK_TX_OFF = 2'b00,
      MSK_TX_IDLE = 2'b01,
      MSK_TX_SEND = 2'b10
   } msk_tx_state_e;
   typedef enum logic [1:0] {
      MSK_RX_HUNT = 2'b00,
      MSK_RX_LOCK = 2'b01,
      MSK_RX_DATA = 2'b10
   } msk_rx_state_e;
endpackage

// ==== src/msk_rx_slicer.sv ====
// Sample window of the receiver that judges each bitcell against the Manchester rule.
`timescale 1ns/1ps
module msk_rx_slicer #(
   parameter int SPB = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sample_en,
   input wire logic clear,
   input wire logic line,
   output logic samp_valid_q,
   output logic manch_ok_q,
   output logic manch_bit_q
);
   localparam int HALF = SPB / 2;
   logic [SPB-1:0] win_q;
   logic [SPB-1:0] win_d;
   logic first_hi, first_lo, second_hi, second_lo;

   if (SPB < 2 || SPB % 2 != 0) begin : g_chk
      $error("msk_rx_slicer needs an even sample count of at least two");
   end

   assign win_d = {win_q[SPB-2:0], line};
   assign first_hi = &win_d[SPB-1:HALF];
   assign first_lo = ~|win_d[SPB-1:HALF];
   assign second_hi = &win_d[HALF-1:0];
   assign second_lo = ~|win_d[HALF-1:0];

   // An all-zero window after a clear never passes, so a stale window cannot lock.
   always_ff @(posedge ref_clk) begin
      if (rst || clear) begin
         win_q <= '0;
         samp_valid_q <= 1'b0;
         manch_ok_q <= 1'b0;
         manch_bit_q <= 1'b0;
      end else begin
         samp_valid_q <= sample_en;
         if (sample_en) begin
            win_q <= win_d;
            manch_ok_q <= (first_hi & second_lo) | (first_lo & second_hi); // R5
            manch_bit_q <= second_hi;
         end
      end
   end
endmodule

// ==== src/msk_modem_regs.sv ====
// Register interface, Manchester transmitter and receiver framing of the MSK modem.
`timescale 1ns/1ps
// Operation
// R1: Control bits 7..4 hold preamble nibble.
// R2: Control bits 3..2 select 1200 to 4800 baud.
// R3: Transmitter enabled and idle drives code 100.
// R4: Transmitter disabled forces code 111; the code first finishes a byte already in progress.
// R5: Receiver enabled scans line for Manchester data.
// R6: Both enables clear gate the modem clock; the code keeps it running until a byte in progress is sent.
// R7: Status bit 7 inverts the line input.
// R8: Full flag set on byte, cleared read/disable.
// R9: Error flag on bad bit, cleared three ways.
// R10: Preamble flag after lock, cleared disable/error.
// R11: Lock flag before preamble, cleared error/disable.
// R12: Transmit flag set when buffer accepts byte.
// R13: Software writing one sets transmit flag.
// R14: Receive flag set by any receive flag.
// R15: Receive flag cleared by read or zero.
// R16: Buffer write loads and starts transmission.
// R17: Overwrite before transmit flag loses old byte.
// R18: Software writes only after transmit flag sets.
// R19: Buffer read returns the received byte.
// R20: Buffer writes and reads use separate registers.
// R21: Bytes are sent most significant bit first.
// R22: One is low-to-high, zero high-to-low.
// R23: Both interrupt flags OR into one request.
// R24: Hardware set beats same-cycle software clear.
module msk_modem_regs
   import msk_pkg::*;
#(
   parameter int SAMPLE_DIV_1200 = msk_pkg::MSK_SAMPLE_DIV_BASE
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic rx_line_in,
   output logic [2:0] dac_code_out,
   output logic msk_irq,
   output logic modem_clk_active
);
   import msk_pkg::*;

   localparam int SPB = MSK_SAMPLES_PER_BIT;
   localparam int PW = $clog2(SPB);
   localparam int BW = $clog2(MSK_BYTE_BITS);
   localparam logic [15:0] DIV_1200 = 16'(SAMPLE_DIV_1200 - 1);
   localparam logic [15:0] DIV_2400 = 16'(SAMPLE_DIV_1200 / 2 - 1);
   localparam logic [15:0] DIV_3600 = 16'(SAMPLE_DIV_1200 / 3 - 1);
   localparam logic [15:0] DIV_4800 = 16'(SAMPLE_DIV_1200 / 4 - 1);
   localparam logic [PW-1:0] LAST_SAMP = PW'(SPB - 1);
   localparam logic [PW-1:0] HALF_SAMP = PW'(SPB / 2);
   localparam logic [BW-1:0] LAST_BIT = BW'(MSK_BYTE_BITS - 1);
   localparam logic [1:0] LOCK_LAST = 2'(MSK_LOCK_BITS - 1);

   if (SAMPLE_DIV_1200 < 8 || SAMPLE_DIV_1200 > 65535) begin : g_chk
      $error("SAMPLE_DIV_1200 must lie between 8 and 65535");
   end

   logic [7:0] ctrl_q;
   logic [7:0] rx_buf_q, tx_hold_q, tx_shift_q, rx_shift_q, rdata_q;
   logic [15:0] div_q, div_max, pre_q;
   logic [15:0] pre_word;
   logic tx_full_q, tx_irq_q, rx_irq_q, rx_full_q, rx_err_q, pre_flag_q, lock_q, pol_q;
   logic [2:0] dac_q, dac_d;
   logic [PW-1:0] tx_samp_q, rph_q;
   logic [BW-1:0] tx_bit_q, rx_bit_q;
   logic [1:0] lock_cnt_q;
   msk_tx_state_e tx_state_q;
   msk_rx_state_e rx_state_q;
   logic tx_en, rx_en, tick, ctrl_wr, buf_wr, stat_wr, buf_rd, tx_load, tx_byte_end;
   logic samp_valid, manch_ok, manch_bit, chk, bit_ok, bit_bad;
   logic lock_set, err_set, pre_set, full_set, rx_irq_sw_clr;

   assign tx_en = ctrl_q[MSK_CTRL_TX_EN];
   assign rx_en = ctrl_q[MSK_CTRL_RX_EN];
   assign ctrl_wr = sfr_wr && (sfr_addr == MSK_ADDR_CTRL);
   assign buf_wr = sfr_wr && (sfr_addr == MSK_ADDR_BUF);
   assign stat_wr = sfr_wr && (sfr_addr == MSK_ADDR_STAT);
   assign buf_rd = sfr_rd && (sfr_addr == MSK_ADDR_BUF);

   // The modem stays clocked while a byte drains after the transmitter is disabled.
   assign modem_clk_active = tx_en || rx_en || (tx_state_q == MSK_TX_SEND); // R6

   always_comb begin
      unique case (ctrl_q[MSK_CTRL_BAUD_HI:MSK_CTRL_BAUD_LO]) // R2
         MSK_BAUD_1200: div_max = DIV_1200;
         MSK_BAUD_2400: div_max = DIV_2400;
         MSK_BAUD_3600: div_max = DIV_3600;
         MSK_BAUD_4800: div_max = DIV_4800;
      endcase
   end

   // Sample-rate enable at eight times the baud rate, shared by both directions.
   always_ff @(posedge ref_clk) begin
      if (rst || !modem_clk_active) begin
         div_q <= '0;
      end else if (div_q >= div_max) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end
   assign tick = modem_clk_active && (div_q >= div_max); // R6

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= MSK_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= sfr_wdata; // R1 R2
      end
   end

   // Transmit path. A byte moves from the hold register to the shifter when one is waiting.
   assign tx_byte_end = (tx_state_q == MSK_TX_SEND) && tick && (tx_samp_q == LAST_SAMP)
                        && (tx_bit_q == LAST_BIT);
   assign tx_load = tx_en && tx_full_q
                    && ((tx_state_q == MSK_TX_IDLE) || tx_byte_end); // R16

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_hold_q <= '0;
         tx_full_q <= 1'b0;
      end else if (buf_wr) begin
         tx_hold_q <= sfr_wdata; // R17 R20
         tx_full_q <= 1'b1;
      end else if (tx_load) begin
         tx_full_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_state_q <= MSK_TX_OFF;
         tx_shift_q <= '0;
         tx_samp_q <= '0;
         tx_bit_q <= '0;
      end else begin
         unique case (tx_state_q)
            MSK_TX_OFF: begin
               if (tx_en) begin
                  tx_state_q <= MSK_TX_IDLE; // R3
               end
            end
            MSK_TX_IDLE: begin
               if (!tx_en) begin
                  tx_state_q <= MSK_TX_OFF; // R4
               end else if (tx_load) begin
                  tx_state_q <= MSK_TX_SEND; // R16
                  tx_shift_q <= tx_hold_q;
                  tx_samp_q <= '0;
                  tx_bit_q <= '0;
               end
            end
            MSK_TX_SEND: begin
               if (tick) begin
                  tx_samp_q <= tx_samp_q + 1'b1;
                  if (tx_samp_q == LAST_SAMP) begin
                     if (tx_bit_q != LAST_BIT) begin
                        tx_bit_q <= tx_bit_q + 1'b1;
                        tx_shift_q <= {tx_shift_q[6:0], 1'b0}; // R21
                     end else if (tx_load) begin
                        tx_bit_q <= '0;
                        tx_shift_q <= tx_hold_q;
                     end else begin
                        // A disabled transmitter finishes its byte before going off.
                        tx_state_q <= tx_en ? MSK_TX_IDLE : MSK_TX_OFF; // R4
                     end
                  end
               end
            end
            default: tx_state_q <= MSK_TX_OFF;
         endcase
      end
   end

   always_comb begin
      dac_d = MSK_DAC_OFF; // R4
      if (tx_state_q == MSK_TX_IDLE) begin
         dac_d = MSK_DAC_IDLE; // R3
      end else if (tx_state_q == MSK_TX_SEND) begin
         if (tx_samp_q < HALF_SAMP) begin
            dac_d = tx_shift_q[7] ? MSK_DAC_LOW : MSK_DAC_HIGH; // R22
         end else begin
            dac_d = tx_shift_q[7] ? MSK_DAC_HIGH : MSK_DAC_LOW; // R22
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dac_q <= MSK_DAC_OFF;
      end else begin
         dac_q <= dac_d;
      end
   end
   assign dac_code_out = dac_q;

   // Receive path.
   msk_rx_slicer #(
      .SPB(SPB)
   ) u_slicer (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_en(tick && rx_en),
      .clear(!rx_en),
      .line(rx_line_in ^ pol_q), // R7
      .samp_valid_q(samp_valid),
      .manch_ok_q(manch_ok),
      .manch_bit_q(manch_bit)
   );

   // While hunting with no good cell counted every sample is tried; otherwise only whole cells.
   assign chk = ((rx_state_q == MSK_RX_HUNT) && (lock_cnt_q == 2'h0)) || (rph_q == LAST_SAMP);
   assign bit_ok = rx_en && samp_valid && chk && manch_ok;
   assign bit_bad = rx_en && samp_valid && chk && !manch_ok;
   assign pre_word = {pre_q[14:0], manch_bit};
   assign lock_set = bit_ok && (rx_state_q == MSK_RX_HUNT) && (lock_cnt_q == LOCK_LAST); // R11
   assign err_set = bit_bad && (rx_state_q != MSK_RX_HUNT); // R9
   assign pre_set = bit_ok && (rx_state_q == MSK_RX_LOCK)
                    && (pre_word == {MSK_PREAMBLE_FIXED, ctrl_q[MSK_CTRL_PRE_HI:MSK_CTRL_PRE_LO]}); // R10
   assign full_set = bit_ok && (rx_state_q == MSK_RX_DATA) && (rx_bit_q == LAST_BIT); // R8

   always_ff @(posedge ref_clk) begin
      if (rst || !rx_en) begin
         rx_state_q <= MSK_RX_HUNT;
         rph_q <= '0;
         lock_cnt_q <= '0;
         pre_q <= '0;
         rx_shift_q <= '0;
         rx_bit_q <= '0;
      end else if (samp_valid) begin
         rph_q <= (chk && manch_ok) ? '0 : rph_q + 1'b1;
         if (bit_ok) begin
            pre_q <= pre_word;
         end
         unique case (rx_state_q)
            MSK_RX_HUNT: begin
               if (lock_set) begin
                  rx_state_q <= MSK_RX_LOCK; // R11
                  lock_cnt_q <= '0;
               end else if (bit_ok) begin
                  lock_cnt_q <= lock_cnt_q + 2'h1;
               end else if (bit_bad) begin
                  lock_cnt_q <= '0;
               end
            end
            MSK_RX_LOCK: begin
               if (bit_bad) begin
                  rx_state_q <= MSK_RX_HUNT; // R9
               end else if (pre_set) begin
                  rx_state_q <= MSK_RX_DATA; // R10
                  rx_bit_q <= '0;
               end
            end
            MSK_RX_DATA: begin
               if (bit_bad) begin
                  rx_state_q <= MSK_RX_HUNT; // R9
               end else if (bit_ok) begin
                  rx_shift_q <= {rx_shift_q[6:0], manch_bit};
                  rx_bit_q <= rx_bit_q + 1'b1;
               end
            end
            default: rx_state_q <= MSK_RX_HUNT;
         endcase
      end
   end

   // The receive register is separate from the transmit hold register.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_buf_q <= '0;
      end else if (full_set) begin
         rx_buf_q <= {rx_shift_q[6:0], manch_bit}; // R20
      end
   end

   // Status flags. Every hardware set is tested before any clear.
   assign rx_irq_sw_clr = stat_wr && !sfr_wdata[MSK_ST_RX_IRQ];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {pol_q, rx_full_q, rx_err_q, pre_flag_q, lock_q, tx_irq_q, rx_irq_q} <= '0;
      end else begin
         if (stat_wr) begin
            pol_q <= sfr_wdata[MSK_ST_POL]; // R7
         end
         if (full_set) begin
            rx_full_q <= 1'b1; // R24
         end else if (buf_rd || !rx_en) begin
            rx_full_q <= 1'b0; // R8
         end
         if (err_set) begin
            rx_err_q <= 1'b1; // R24
         end else if (buf_rd || !rx_en || rx_irq_sw_clr) begin
            rx_err_q <= 1'b0; // R9 R15
         end
         if (pre_set) begin
            pre_flag_q <= 1'b1;
         end else if (!rx_en || err_set) begin
            pre_flag_q <= 1'b0; // R10
         end
         if (lock_set) begin
            lock_q <= 1'b1;
         end else if (!rx_en || err_set) begin
            lock_q <= 1'b0; // R11
         end
         if (tx_load || (stat_wr && sfr_wdata[MSK_ST_TX_IRQ])) begin
            tx_irq_q <= 1'b1; // R12 R13 R24
         end else if (buf_wr || stat_wr) begin
            tx_irq_q <= 1'b0; // R12
         end
         if (full_set || err_set || pre_set || lock_set) begin
            rx_irq_q <= 1'b1; // R14 R24
         end else if (buf_rd || rx_irq_sw_clr) begin
            rx_irq_q <= 1'b0; // R15
         end
      end
   end

   assign msk_irq = tx_irq_q || rx_irq_q; // R23

   // Read data are registered and appear one cycle after the strobe.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= MSK_READ_ZERO;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            MSK_ADDR_CTRL: rdata_q <= ctrl_q;
            MSK_ADDR_BUF: rdata_q <= rx_buf_q; // R19
            MSK_ADDR_STAT: rdata_q <= {pol_q, 1'b0, rx_full_q, rx_err_q, pre_flag_q, lock_q,
                                       tx_irq_q, rx_irq_q};
            default: rdata_q <= MSK_READ_ZERO;
         endcase
      end
   end
   assign sfr_rdata = rdata_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_tx_start;
      tx_load ##1 (tx_state_q == MSK_TX_SEND);
   endsequence

   a_dac_idle_code: assert property ((tx_state_q == MSK_TX_IDLE) |=> (dac_code_out == MSK_DAC_IDLE)) // R3
      else $error("idle transmitter not at idle code");
   a_dac_off_code: assert property ((!tx_en && tx_state_q != MSK_TX_SEND) |=> ##1 (dac_code_out == MSK_DAC_OFF)) // R4
      else $error("disabled transmitter not at off code");
   a_tx_msb_first: assert property (s_tx_start |=> (dac_code_out == ($past(tx_hold_q[7], 2) ? MSK_DAC_LOW : MSK_DAC_HIGH))) // R21
      else $error("first half cell does not code the top bit");
   a_full_rd_clear: assert property ((buf_rd && !full_set) |=> !rx_full_q) // R8
      else $error("full flag survived a buffer read");
   a_err_clears: assert property (((buf_rd || !rx_en || rx_irq_sw_clr) && !err_set) |=> !rx_err_q) // R9
      else $error("error flag survived a clear");
   a_error_drops_sync: assert property (err_set |=> (!pre_flag_q && !lock_q && rx_err_q)) // R10
      else $error("coding error left lock or preamble set");
   a_tx_flag_write: assert property ((buf_wr && !tx_load) |=> !tx_irq_q) // R12
      else $error("buffer write did not clear transmit flag");
   a_tx_flag_soft_set: assert property ((stat_wr && sfr_wdata[MSK_ST_TX_IRQ]) |=> (tx_irq_q && msk_irq)) // R13
      else $error("software set of transmit flag failed");
   a_rx_irq_event: assert property ((full_set || err_set || pre_set || lock_set) |=> (rx_irq_q && msk_irq)) // R14
      else $error("receive event did not raise receive flag");
   a_rx_read_data: assert property (buf_rd |=> (sfr_rdata == $past(rx_buf_q))) // R19
      else $error("buffer read returned wrong byte");
   a_set_wins: assert property ((full_set && buf_rd) |=> rx_full_q) // R24
      else $error("clear beat a same-cycle set");
endmodule

// ==== tb/msk_line_model.sv ====
// Far-side model: decodes the resistive DAC waveform and drives a Manchester line.
`timescale 1ns/1ps
module msk_line_model
   import msk_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [2:0] dac_code_out,
   input wire logic [15:0] tick_cyc,
   input wire logic invert,
   output logic rx_line_in
);
   logic [7:0] rx_bytes[$];
   logic [7:0] shift_q = 8'h00;
   logic [2:0] first_half;
   logic half_bad = 1'h0;
   int frame_cyc = 0;
   int run_cyc = 0;
   int chg_cyc = 0;
   logic [2:0] last_code = 3'h0;
   int nbits;

   function automatic logic is_half(input logic [2:0] c);
      return (c === MSK_DAC_HIGH) || (c === MSK_DAC_LOW);
   endfunction

   initial rx_line_in = 1'h0;

   // Burst length from the first mid-cell edge, so the bench can check the bit rate.
   // The first half-cell starts between sample ticks, so its length is left out.
   always @(negedge ref_clk) begin
      last_code <= dac_code_out;
      if (is_half(dac_code_out)) begin
         run_cyc <= run_cyc + 1;
         if (chg_cyc == 0 && run_cyc != 0 && dac_code_out !== last_code) begin
            chg_cyc <= run_cyc;
         end
      end else if (run_cyc != 0) begin
         frame_cyc <= run_cyc - chg_cyc;
         run_cyc <= 0;
         chg_cyc <= 0;
      end
   end

   // Halves are sampled in their middle, two ticks in, so edge jitter never matters.
   initial forever begin
      @(negedge ref_clk);
      if (is_half(dac_code_out)) begin
         nbits = 0;
         repeat (2 * tick_cyc - 1) @(negedge ref_clk);
         while (is_half(dac_code_out)) begin
            first_half = dac_code_out;
            repeat (4 * tick_cyc) @(negedge ref_clk);
            if (!is_half(dac_code_out) || dac_code_out === first_half) begin
               half_bad = 1'h1;
            end
            shift_q = {shift_q[6:0], first_half === MSK_DAC_LOW};
            nbits++;
            if (nbits % 8 == 0) begin
               rx_bytes.push_back(shift_q);
            end
            repeat (4 * tick_cyc) @(negedge ref_clk);
         end
      end
   end

   // Each half lasts four sample ticks; a quiet channel holds one level.
   task automatic send(input logic [23:0] bits);
      // A quiet cell first, so a level left by an earlier polarity cannot fake a half-cell.
      @(negedge ref_clk);
      rx_line_in = invert;
      repeat (8 * tick_cyc - 1) @(negedge ref_clk);
      for (int i = 23; i >= 0; i--) begin
         for (int h = 0; h < 2; h++) begin
            @(negedge ref_clk);
            rx_line_in = (h == 1) ? (bits[i] ^ invert) : (~bits[i] ^ invert);
            repeat (4 * tick_cyc - 1) @(negedge ref_clk);
         end
      end
      @(negedge ref_clk);
      rx_line_in = invert;
   endtask
endmodule

// ==== tb/test_msk_modem_regs.sv ====
// Self-checking testbench of the MSK modem register block.
`timescale 1ns/1ps
module test_msk_modem_regs;
   import msk_pkg::*;
   logic ref_clk, rst, sfr_wr, sfr_rd, pol_q, msk_irq, modem_clk_active, rx_line_in;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, lfsr_q, s, v, a, bb, c, dat;
   logic [2:0] dac_code_out;
   logic [15:0] tc_q;
   int bad_count = 0;
   int n_tests = 0;
   int i;

   msk_modem_regs #(.SAMPLE_DIV_1200(8)) DUT (.ref_clk(ref_clk), .rst(rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .rx_line_in(rx_line_in), .dac_code_out(dac_code_out),
      .msk_irq(msk_irq), .modem_clk_active(modem_clk_active));
   msk_line_model line (.ref_clk(ref_clk), .dac_code_out(dac_code_out), .tick_cyc(tc_q),
      .invert(pol_q), .rx_line_in(rx_line_in));

   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] q);
      return {q[6:0], q[7] ^ q[5] ^ q[4] ^ q[3]};
   endfunction

   // Cycles per sample tick with the shortened divider of 8.
   function automatic logic [15:0] tick_of(input int sel);
      return 16'(8 / (sel + 1));
   endfunction

   task automatic rnd(output logic [7:0] r);
      lfsr_q = lfsr_next(lfsr_q);
      r = lfsr_q;
   endtask

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] dv);
      @(negedge ref_clk);
      sfr_addr = ad;
      sfr_wdata = dv;
      sfr_wr = 1'h1;
      @(negedge ref_clk);
      sfr_wr = 1'h0;
   endtask

   task automatic rd(input logic [7:0] ad, output logic [7:0] dv);
      @(negedge ref_clk);
      sfr_addr = ad;
      sfr_rd = 1'h1;
      @(negedge ref_clk);
      sfr_rd = 1'h0;
      @(negedge ref_clk);
      dv = sfr_rdata;
   endtask

   task automatic poll(input int bitn, output logic [7:0] dv);
      int k;
      for (k = 0; k < 4000; k++) begin
         rd(MSK_ADDR_STAT, dv);
         if (dv[bitn] === 1'h1) break;
      end
      if (k == 4000) begin
         bad_count++;
         $display("wrong value status_bit_%0d expected 1 seen 0", bitn);
         print_verdict();
      end
   endtask

   initial begin
      rst = 1'h1;
      sfr_wr = 1'h0;
      sfr_rd = 1'h0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      pol_q = 1'h0;
      tc_q = 16'h0009;
      lfsr_q = 8'h60;
      repeat (16) @(negedge ref_clk);
      rst = 1'h0;
      check("dac_reset", dac_code_out, MSK_DAC_OFF);
      check("clk_reset", modem_clk_active, 1'h0);
      check("irq_reset", msk_irq, 1'h0);
      rd(MSK_ADDR_CTRL, s);
      check("ctrl_reset", s, MSK_CTRL_RESET);
      rd(MSK_ADDR_STAT, s);
      check("stat_reset", s, MSK_STAT_RESET);
      rd(8'hcb, s);
      check("unmapped", s, MSK_READ_ZERO);
      for (i = 0; i < 4; i++) begin
         rnd(v);
         wr(MSK_ADDR_CTRL, {v[7:2], 2'h0});
         rd(MSK_ADDR_CTRL, s);
         check("ctrl_fields", s, {v[7:2], 2'h0});
         check("clk_gated", modem_clk_active, 1'h0);
      end
      wr(8'hcb, 8'hff);
      rd(MSK_ADDR_CTRL, s);
      check("ctrl_unmapped_wr", s, {v[7:2], 2'h0});
      // Flag bits 5..2 and the unused bit ignore software; only polarity and the transmit flag would stick.
      wr(MSK_ADDR_STAT, 8'h7c);
      rd(MSK_ADDR_STAT, s);
      check("stat_ro", s, 8'h00);
      $display("test registers done");
      for (int b = 0; b < 4; b++) begin
         tc_q = tick_of(b);
         line.rx_bytes.delete();
         wr(MSK_ADDR_CTRL, {4'h0, b[1:0], 2'h2});
         repeat (3) @(negedge ref_clk);
         check("dac_idle", dac_code_out, MSK_DAC_IDLE);
         check("clk_tx", modem_clk_active, 1'h1);
         rnd(a);
         rnd(bb);
         rnd(c);
         wr(MSK_ADDR_BUF, a);
         poll(MSK_ST_TX_IRQ, s);
         // The second byte is overwritten before it was taken, so it never goes out.
         wr(MSK_ADDR_BUF, bb);
         wr(MSK_ADDR_BUF, c);
         for (i = 0; i < 4000; i++) begin
            @(negedge ref_clk);
            if (line.rx_bytes.size() >= 2 && dac_code_out === MSK_DAC_IDLE) break;
         end
         if (i == 4000) begin
            bad_count++;
            $display("wrong value tx_frame_end expected idle seen busy");
            print_verdict();
         end
         @(negedge ref_clk);
         check("tx_count", line.rx_bytes.size(), 2);
         check("tx_byte0", line.rx_bytes[0], a);
         check("tx_byte1", line.rx_bytes[1], c);
         check("tx_halves", line.half_bad, 1'h0);
         check("tx_length", line.frame_cyc, 124 * tc_q);
         rd(MSK_ADDR_STAT, s);
         check("tx_flag", s[MSK_ST_TX_IRQ], 1'h1);
         check("irq_tx", msk_irq, 1'h1);
         wr(MSK_ADDR_STAT, 8'h00);
         rd(MSK_ADDR_STAT, s);
         check("tx_flag_clr", s[MSK_ST_TX_IRQ], 1'h0);
         check("irq_clr", msk_irq, 1'h0);
         wr(MSK_ADDR_STAT, 8'h02);
         repeat (2) @(negedge ref_clk);
         check("irq_soft", msk_irq, 1'h1);
         wr(MSK_ADDR_STAT, 8'h00);
         wr(MSK_ADDR_CTRL, 8'h00);
         repeat (3) @(negedge ref_clk);
         check("dac_off", dac_code_out, MSK_DAC_OFF);
         check("clk_off", modem_clk_active, 1'h0);
         $display("test transmit rate %0d done", b);
      end
      for (int b = 0; b < 4; b++) begin
         tc_q = tick_of(b);
         rnd(v);
         rnd(dat);
         pol_q = v[4];
         wr(MSK_ADDR_STAT, {pol_q, 7'h00});
         wr(MSK_ADDR_CTRL, {v[3:0], b[1:0], 2'h1});
         fork
            line.send({12'haaa, v[3:0], dat});
            begin
               poll(MSK_ST_FULL, s);
               check("rx_full_stat", s, {pol_q, 7'h2d});
               rd(MSK_ADDR_BUF, a);
               check("rx_byte", a, dat);
               rd(MSK_ADDR_STAT, s);
               check("rx_after_read", s, {pol_q, 7'h0c});
            end
         join
         // A silent line after the frame is a coding violation once locked.
         poll(MSK_ST_ERR, s);
         check("rx_err_stat", s, {pol_q, 7'h11});
         check("irq_rx", msk_irq, 1'h1);
         wr(MSK_ADDR_STAT, {pol_q, 7'h00});
         rd(MSK_ADDR_STAT, s);
         check("rx_flag_clr", s, {pol_q, 7'h00});
         check("irq_rx_clr", msk_irq, 1'h0);
         wr(MSK_ADDR_CTRL, 8'h00);
         $display("test receive rate %0d done", b);
      end
      print_verdict();
   end
endmodule
